// ---- sci_channel.sv ----
// Serial channel: UART error recovery and simplified I2C address frame.
// Assumes APB master on pclk; receive characters arrive on pclk;
// SCL and SDA are open-drain pins resolved outside.
`timescale 1ns/1ns
`default_nettype none

module sci_channel (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Receive characters from the channel shifter
    input wire sci_pkg::sci_rxchar_t rx_char,
    // Serial pins, open drain
    output logic ch0_serial_clock_pin_o,
    output logic ch0_serial_clock_pin_oe,
    input wire logic ch0_serial_data_pin_i,
    output logic ch0_serial_data_pin_o,
    output logic ch0_serial_data_pin_oe,
    // Transfer end event
    output logic i2c_ch0_transfer_end_irq
);
    import sci_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [15:0] mode_reg, mode_next;
    logic [15:0] comm_reg, comm_next;
    logic [15:0] data_reg, data_next;
    logic [15:0] olvl_reg, olvl_next;
    logic ogate_reg, ogate_next;
    logic enab_reg, enab_next;
    logic ovf_reg, ovf_next;
    logic per_reg, per_next;
    logic fer_reg, fer_next;
    logic bfull_reg, bfull_next;
    logic ready_reg, ready_next;
    logic [31:0] rdata_reg, rdata_next;
    logic err_reg, err_next;
    sci_state_t state_reg, state_next;
    logic [7:0] shift_reg, shift_next;
    logic [3:0] bit_reg, bit_next;
    logic [7:0] cnt_reg, cnt_next;
    logic irq_reg, irq_next;
    logic scl_next, sda_next;
    // Pin pull enables, registered so the outputs come from flops
    logic scl_oe_reg, scl_oe_next;
    logic sda_oe_reg, sda_oe_next;
    logic sync1_reg, sync2_reg;

    logic wr_ok, rd_ok, mapped, i2c_mode, cfg_ok, frame_go;
    logic [6:0] div;
    logic [7:0] half;
    logic cnt_end, ack_seen;
    sci_stat_t stat;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Access phase completes on the second cycle
    // One wait state: pready rises in the second access cycle only
    assign wr_ok = psel & penable & ready_reg & pwrite;
    assign rd_ok = psel & penable & ready_reg & ~pwrite;
    // Any aligned offset up to the last register is mapped
    assign mapped = (paddr <= SCI_OFF_ENAB) & (paddr[1:0] == 2'h0);
    // Mode field selects the I2C behaviour of the channel
    assign i2c_mode = mode_reg[SCI_MD_LSB+:2] == SCI_MD_I2C;
    // Only no-parity with one ACK bit is a legal I2C frame
    assign cfg_ok = (comm_reg[SCI_PTC_LSB+:2] == SCI_PTC_NONE)
                  & (comm_reg[SCI_SLC_LSB+:2] == SCI_SLC_ACK);
    // Data write while running launches the address frame
    // A write while busy only updates the register, the frame runs on
    assign frame_go = wr_ok & (paddr == SCI_OFF_DATA) & enab_reg & i2c_mode
                    & cfg_ok & comm_reg[SCI_TXE_BIT]
                    & (state_reg == SCI_ST_IDLE);
    // Divider clamped so SCL never passes pclk over four
    // A divider of zero would give SCL at half of pclk
    assign div = (data_reg[15:SCI_DIV_LSB] < SCI_DIV_MIN) ? SCI_DIV_MIN
               : data_reg[15:SCI_DIV_LSB];
    // Each half of a bit lasts divider plus one pclk cycles
    assign half = {1'b0, div} + 8'h01;
    assign cnt_end = cnt_reg == (half - 8'h01);
    // ACK level seen two cycles late through the synchroniser
    assign ack_seen = sync2_reg;

    // Status view
    // A data read clears bfull; no other read changes a flag, only the clear register does
    always_comb begin
        stat = '0;
        stat.ovf = ovf_reg;
        stat.per = per_reg;
        stat.fer = fer_reg;
        stat.bfull = bfull_reg;
        stat.busy = state_reg != SCI_ST_IDLE;
    end

    // ------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------
    // Read mux and ready generation
    always_comb begin
        ready_next = psel & penable & ~ready_reg;
        rdata_next = rdata_reg;
        err_next = 1'b0;
        if (psel & penable & ~ready_reg) begin
            // Unmapped or misaligned places answer with an error and zero
            err_next = ~mapped;
            rdata_next = 32'h00000000;
            unique case (paddr)
                SCI_OFF_MODE: rdata_next = {16'h0000, mode_reg};
                SCI_OFF_COMM: rdata_next = {16'h0000, comm_reg};
                SCI_OFF_DATA: rdata_next = {16'h0000, data_reg};
                SCI_OFF_STAT: rdata_next = {16'h0000, stat};
                SCI_OFF_OLVL: rdata_next = {16'h0000, olvl_reg};
                SCI_OFF_OGATE: rdata_next = {31'h0, ogate_reg};
                SCI_OFF_ENAB: rdata_next = {31'h0, enab_reg};
                default: rdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            err_reg <= 1'b0;
        end else begin
            ready_reg <= ready_next;
            rdata_reg <= rdata_next;
            err_reg <= err_next;
        end
    end

    // ------------------------------------------------------------
    // Registers and flags
    // ------------------------------------------------------------
    // Software writes, hardware sets win over clears
    // A set in the cycle of a clear survives, so no error goes unseen
    always_comb begin
        mode_next = mode_reg;
        comm_next = comm_reg;
        data_next = data_reg;
        olvl_next = olvl_reg;
        ogate_next = ogate_reg;
        enab_next = enab_reg;
        ovf_next = ovf_reg;
        per_next = per_reg;
        fer_next = fer_reg;
        bfull_next = bfull_reg;
        if (wr_ok) begin
            unique case (paddr)
                SCI_OFF_MODE: mode_next = pwdata[15:0];
                SCI_OFF_COMM: comm_next = pwdata[15:0];
                SCI_OFF_DATA: data_next = pwdata[15:0];
                SCI_OFF_OLVL: olvl_next = pwdata[15:0];
                SCI_OFF_OGATE: ogate_next = pwdata[SCI_CH_BIT];
                SCI_OFF_FCLR: begin
                    if (pwdata[0]) ovf_next = 1'b0;
                    if (pwdata[1]) per_next = 1'b0;
                    if (pwdata[2]) fer_next = 1'b0;
                end
                SCI_OFF_START: begin
                    if (pwdata[SCI_CH_BIT]) enab_next = 1'b1;
                end
                SCI_OFF_STOP: begin
                    if (pwdata[SCI_CH_BIT]) enab_next = 1'b0;
                end
                // Read-only places simply ignore the write
                default: ;
            endcase
        end
        // Data read frees the buffer
        if (rd_ok & (paddr == SCI_OFF_DATA)) begin
            bfull_next = 1'b0;
        end
        // UART errors only outside I2C mode
        if (rx_char.valid & enab_reg & ~i2c_mode) begin
            if (bfull_reg & ~(rd_ok & (paddr == SCI_OFF_DATA))) begin
                // Overrun keeps the older character, the new one is lost
                ovf_next = 1'b1;
            end else begin
                data_next[7:0] = rx_char.data;
            end
            bfull_next = 1'b1;
            if (rx_char.parity_err) per_next = 1'b1;
            if (rx_char.framing_err) fer_next = 1'b1;
        end
        // High level in the ACK slot flags an ACK error
        // Sampled in the last cycle of the high half of that slot
        if ((state_reg == SCI_ST_HIGH) & (bit_reg == SCI_LAST_BIT)
            & cnt_end & ack_seen) begin
            per_next = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= SCI_RST16;
            comm_reg <= SCI_RST16;
            data_reg <= SCI_RST16;
            olvl_reg <= SCI_OLVL_RST;
            ogate_reg <= 1'b0;
            enab_reg <= 1'b0;
            ovf_reg <= 1'b0;
            per_reg <= 1'b0;
            fer_reg <= 1'b0;
            bfull_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            comm_reg <= comm_next;
            data_reg <= data_next;
            olvl_reg <= olvl_next;
            ogate_reg <= ogate_next;
            enab_reg <= enab_next;
            ovf_reg <= ovf_next;
            per_reg <= per_next;
            fer_reg <= fer_next;
            bfull_reg <= bfull_next;
        end
    end

    // ------------------------------------------------------------
    // SDA input synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Idle high, so no false ACK follows reset
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
        end else begin
            sync1_reg <= ch0_serial_data_pin_i;
            sync2_reg <= sync1_reg;
        end
    end

    // ------------------------------------------------------------
    // Address frame shifter, master only, no arbitration or wait
    // ------------------------------------------------------------
    // Each bit: SCL low half, then SCL high half; bit 8 is the ACK slot
    always_comb begin
        state_next = state_reg;
        shift_next = shift_reg;
        bit_next = bit_reg;
        cnt_next = cnt_reg;
        irq_next = 1'b0;
        unique case (state_reg)
            SCI_ST_IDLE: begin
                // Counters held at zero so every frame starts from bit 0
                cnt_next = 8'h00;
                bit_next = 4'h0;
                if (frame_go) begin
                    shift_next = pwdata[7:0];
                    state_next = SCI_ST_LOW;
                end
            end
            SCI_ST_LOW: begin
                cnt_next = cnt_reg + 8'h01;
                if (cnt_end) begin
                    cnt_next = 8'h00;
                    state_next = SCI_ST_HIGH;
                end
            end
            SCI_ST_HIGH: begin
                cnt_next = cnt_reg + 8'h01;
                if (cnt_end) begin
                    cnt_next = 8'h00;
                    if (bit_reg == SCI_LAST_BIT) begin
                        // Transfer end pulse, also after a high ACK slot
                        irq_next = 1'b1;
                        state_next = SCI_ST_IDLE;
                    end else begin
                        // Next bit moves to the top, a one fills in behind
                        shift_next = {shift_reg[6:0], 1'b1};
                        bit_next = bit_reg + 4'h1;
                        state_next = SCI_ST_LOW;
                    end
                end
            end
            default: state_next = SCI_ST_IDLE;
        endcase
        // Stop halts the frame at once
        // Pins fall back to the output level bits when a frame is cut
        if (~enab_next) begin
            state_next = SCI_ST_IDLE;
        end
    end

    // Pin levels: shifter drives SDA only when gated on, SCL in every frame
    // Outside a frame both wires follow the output level bits
    always_comb begin
        scl_next = olvl_reg[SCI_CKO_BIT];
        sda_next = olvl_reg[SCI_CH_BIT];
        // Single master: SCL follows the own state and is never read back,
        // so no stretching wait and no arbitration loss can occur
        if (state_next != SCI_ST_IDLE) begin
            scl_next = state_next == SCI_ST_HIGH;
        end
        if (ogate_reg & (state_next != SCI_ST_IDLE)) begin
            // ACK slot released; with the gate off SDA stays at the output level bit, ACK slot included
            sda_next = (bit_next == SCI_LAST_BIT) | shift_next[7];
        end
        // Pull the wire low wherever the wanted level is low
        scl_oe_next = ~scl_next;
        sda_oe_next = ~sda_next;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= SCI_ST_IDLE;
            shift_reg <= 8'hff;
            bit_reg <= 4'h0;
            cnt_reg <= 8'h00;
            irq_reg <= 1'b0;
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            bit_reg <= bit_next;
            cnt_reg <= cnt_next;
            irq_reg <= irq_next;
            scl_oe_reg <= scl_oe_next;
            sda_oe_reg <= sda_oe_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Bus answer straight from its flops
    assign prdata = rdata_reg;
    assign pready = ready_reg;
    assign pslverr = err_reg;
    assign i2c_ch0_transfer_end_irq = irq_reg;
    // Open drain: only low is driven, the pull-up makes the high level
    assign ch0_serial_clock_pin_o = 1'b0;
    // Pull enables straight from flops, no glitch on the wires
    assign ch0_serial_clock_pin_oe = scl_oe_reg;
    assign ch0_serial_data_pin_o = 1'b0;
    assign ch0_serial_data_pin_oe = sda_oe_reg;

endmodule : sci_channel

`default_nettype wire

// ---- sci_channel_asserts.sv ----
// Port checker for the serial channel block.
// Assumes binding onto sci_channel, all signals on pclk.
`timescale 1ns/1ns
`default_nettype none

module sci_channel_asserts (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB answer
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and event
    input wire logic ch0_serial_clock_pin_o,
    input wire logic ch0_serial_clock_pin_oe,
    input wire logic ch0_serial_data_pin_o,
    input wire logic i2c_ch0_transfer_end_irq
);
    import sci_pkg::*;
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking dcb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    setup_no_ready_a: assert property (psel && !penable |=> !pready)
        else $error("pready in first access cycle");
    ready_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing after wait state");
    ready_once_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_access_a: assert property (pready |-> psel && penable && $past(psel))
        else $error("pready outside access phase");
    err_with_ready_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("pslverr without pready or with data");
    upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    pins_low_a: assert property (!ch0_serial_clock_pin_o && !ch0_serial_data_pin_o)
        else $error("open drain output not low");
    irq_pulse_a: assert property (i2c_ch0_transfer_end_irq |=> !i2c_ch0_transfer_end_irq)
        else $error("transfer end longer than one cycle");
    irq_after_high_a: assert property (i2c_ch0_transfer_end_irq |-> !$past(ch0_serial_clock_pin_oe))
        else $error("transfer end not after high half");
    scl_low_hold_a: assert property ($rose(ch0_serial_clock_pin_oe) |-> ch0_serial_clock_pin_oe[*2])
        else $error("clock low half shorter than two cycles");
    // Main scenarios
    frame_end_c: cover property (i2c_ch0_transfer_end_irq);
    refused_c: cover property (pslverr);
    clock_low_c: cover property ($rose(ch0_serial_clock_pin_oe));
endmodule : sci_channel_asserts

bind sci_channel sci_channel_asserts sci_channel_asserts_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ch0_serial_clock_pin_o(ch0_serial_clock_pin_o),
    .ch0_serial_clock_pin_oe(ch0_serial_clock_pin_oe),
    .ch0_serial_data_pin_o(ch0_serial_data_pin_o),
    .i2c_ch0_transfer_end_irq(i2c_ch0_transfer_end_irq));
`default_nettype wire

// ---- sci_i2c_slave.sv ----
// Behavioural I2C slave on the far side of the channel.
// Assumes open-drain wires with pull-ups resolved by the bench.
`timescale 1ns/1ns
`default_nettype none

module sci_i2c_slave (
    // Bus wires
    input wire logic scl,
    input wire logic sda,
    // Bench control
    input wire logic ack_en,
    input wire logic clr,
    // Pull-down and captured byte
    output logic sda_oe,
    output logic [7:0] got
);
    int n_rise = 0;
    int n_fall = 0;
    // ------------------------------------------------------------
    // Capture and acknowledge
    // ------------------------------------------------------------
    // Shift in eight bits on SCL rise, first bit lands on top
    always @(posedge scl or posedge clr) begin
        if (clr) begin
            n_rise <= 0;
        end else if (n_rise < 8) begin
            got <= {got[6:0], sda};
            n_rise <= n_rise + 1;
        end
    end
    // Pull SDA low for the ninth bit; held until the next SCL fall or a clear, past the sample
    always @(negedge scl or posedge clr) begin
        if (clr) begin
            n_fall <= 0;
            sda_oe <= 1'b0;
        end else begin
            n_fall <= n_fall + 1;
            sda_oe <= ack_en && (n_fall == 8);
        end
    end
endmodule : sci_i2c_slave
`default_nettype wire

// ---- sci_pkg.sv ----
// Constants, types and register map of the serial channel block.
// Assumes a 32-bit APB bus and one channel clocked by pclk.
package sci_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SCI_OFF_MODE = 8'h00;
    localparam logic [7:0] SCI_OFF_COMM = 8'h04;
    localparam logic [7:0] SCI_OFF_DATA = 8'h08;
    localparam logic [7:0] SCI_OFF_STAT = 8'h0c;
    localparam logic [7:0] SCI_OFF_FCLR = 8'h10;
    localparam logic [7:0] SCI_OFF_OLVL = 8'h14;
    localparam logic [7:0] SCI_OFF_OGATE = 8'h18;
    localparam logic [7:0] SCI_OFF_START = 8'h1c;
    localparam logic [7:0] SCI_OFF_STOP = 8'h20;
    localparam logic [7:0] SCI_OFF_ENAB = 8'h24;

    // ------------------------------------------------------------
    // Field positions and values
    // ------------------------------------------------------------
    localparam int SCI_MD_LSB = 1;
    localparam logic [1:0] SCI_MD_I2C = 2'h2;
    localparam int SCI_TXE_BIT = 15;
    localparam int SCI_PTC_LSB = 8;
    localparam logic [1:0] SCI_PTC_NONE = 2'h0;
    localparam int SCI_SLC_LSB = 4;
    localparam logic [1:0] SCI_SLC_ACK = 2'h1;
    localparam int SCI_DIV_LSB = 9;
    localparam int SCI_CKO_BIT = 8;
    localparam int SCI_CH_BIT = 0;
    localparam logic [15:0] SCI_RST16 = 16'h0000;
    localparam logic [15:0] SCI_OLVL_RST = 16'h0101;
    localparam logic [6:0] SCI_DIV_MIN = 7'h01;
    localparam logic [3:0] SCI_LAST_BIT = 4'h8;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SCI_ST_IDLE = 2'b00,
        SCI_ST_LOW = 2'b01,
        SCI_ST_HIGH = 2'b10
    } sci_state_t;

    // Status word: bit0 overrun, bit1 ack/parity, bit2 framing,
    // bit5 buffer full, bit6 transfer busy
    typedef struct packed {
        logic [8:0] rsvd;
        logic busy;
        logic bfull;
        logic [1:0] rsvd2;
        logic fer;
        logic per;
        logic ovf;
    } sci_stat_t;

    // Character from the receive shifter of the channel
    typedef struct packed {
        logic valid;
        logic parity_err;
        logic framing_err;
        logic [7:0] data;
    } sci_rxchar_t;

endpackage : sci_pkg

// ---- test_sci_channel.sv ----
// Self-checking bench for the serial channel block.
// Assumes the slave model and the bound checker.
`timescale 1ns/1ns
`default_nettype none

module test_sci_channel;
    import sci_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, d0, d1, addr, slv_got;
    logic [6:0] dv;
    logic [31:0] pwdata, prdata, rdat;
    logic scl_oe, sda_oe, slv_oe, irq, ack_en, slv_clr, rerr;
    sci_rxchar_t rx_char;
    wire scl;
    wire sda;
    int n_fail, n_checks, k;
    int seed = 32'he7d7d3f4;
    // Open-drain wires with pull-ups
    assign scl = !scl_oe;
    assign sda = !(sda_oe || slv_oe);

    sci_channel sci_channel_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_char(rx_char), .ch0_serial_clock_pin_o(),
        .ch0_serial_clock_pin_oe(scl_oe), .ch0_serial_data_pin_i(sda),
        .ch0_serial_data_pin_o(), .ch0_serial_data_pin_oe(sda_oe),
        .i2c_ch0_transfer_end_irq(irq));
    sci_i2c_slave sci_i2c_slave_i (.scl(scl), .sda(sda), .ack_en(ack_en), .clr(slv_clr),
        .sda_oe(slv_oe), .got(slv_got));

    // ------------------------------------------------------------
    // Tasks and expectations
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t value %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One APB transfer, waits for pready under a bound
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) n_fail++;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat & m, e);
    endtask : rd
    task automatic rx(input logic [7:0] d, input logic pe, input logic fe);
        @(posedge pclk);
        rx_char <= {1'b1, pe, fe, d};
        @(posedge pclk);
        rx_char.valid <= 1'b0;
    endtask : rx
    task automatic wait_irq;
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (irq !== 1'b1 && n < 2000);
        chk(32'(n < 2000), 32'h1);
    endtask : wait_irq
    // Status word: bit5 full, bit2 framing, bit1 ack/parity, bit0 overrun
    function automatic logic [31:0] st(input logic ov, input logic pe, input logic fe,
        input logic bf);
        return {26'h0, bf, 2'b00, fe, pe, ov};
    endfunction : st
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        repeat (6000) @(posedge pclk);
        n_fail++;
        test_done;
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, ack_en} = 5'h0;
        {paddr, pwdata, rx_char} = '0;
        slv_clr = 1'b1;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        slv_clr <= 1'b0;
        // Reset values, write-only and unmapped places
        rd(SCI_OFF_STAT, 32'hffff, 32'h0);
        rd(SCI_OFF_OLVL, 32'hffff, 32'h0101);
        rd(SCI_OFF_ENAB, 32'hffff, 32'h0);
        rd(SCI_OFF_START, 32'hffffffff, 32'h0);
        rd(8'h40, 32'hffffffff, 32'h0);
        chk(rerr, 1'b1);
        // Receive errors and recovery
        d0 = 8'($random(seed));
        d1 = 8'($random(seed));
        wr(SCI_OFF_START, 32'h1);
        rd(SCI_OFF_ENAB, 32'h1, 32'h1);
        rx(d0, 1'b1, 1'b1);
        rd(SCI_OFF_STAT, 32'hffff, st(0, 1, 1, 1));
        rd(SCI_OFF_STAT, 32'hffff, st(0, 1, 1, 1));
        rx(d1, 1'b0, 1'b0);
        rd(SCI_OFF_STAT, 32'hffff, st(1, 1, 1, 1));
        rd(SCI_OFF_DATA, 32'hff, {24'h0, d0});
        rd(SCI_OFF_STAT, 32'hffff, st(1, 1, 1, 0));
        wr(SCI_OFF_FCLR, rdat);
        rd(SCI_OFF_STAT, 32'hffff, 32'h0);
        rx(d1, 1'b0, 1'b0);
        rd(SCI_OFF_DATA, 32'hff, {24'h0, d1});
        wr(SCI_OFF_STOP, 32'h1);
        rd(SCI_OFF_ENAB, 32'h1, 32'h0);
        rx(d0, 1'b0, 1'b0);
        rd(SCI_OFF_STAT, 32'hffff, 32'h0);
        wr(SCI_OFF_START, 32'h1);
        rd(SCI_OFF_ENAB, 32'h1, 32'h1);
        // Address frames, acked then refused by the slave
        wr(SCI_OFF_MODE, {29'h0, SCI_MD_I2C, 1'b0});
        wr(SCI_OFF_COMM, 32'h8010);
        for (k = 0; k < 2; k++) begin
            addr = (k == 0) ? 8'hff : 8'($random(seed));
            // Divider 24: 50-cycle bit, 1 MHz; divider 62: 126 cycles, under 400 kHz
            dv = (k == 0) ? 7'h18 : 7'h3e;
            slv_clr <= 1'b1;
            ack_en <= (k == 0);
            @(posedge pclk);
            slv_clr <= 1'b0;
            wr(SCI_OFF_OGATE, 32'h0);
            wr(SCI_OFF_OLVL, 32'h0100);
            repeat (2) @(posedge pclk);
            chk({scl_oe, sda_oe}, 2'b01);
            wr(SCI_OFF_OGATE, 32'h1);
            wr(SCI_OFF_DATA, {16'h0, dv, 1'b0, addr});
            rd(SCI_OFF_STAT, 32'h40, 32'h40);
            wait_irq;
            chk(slv_got, addr);
            rd(SCI_OFF_STAT, 32'hffff, st(0, k == 1, 0, 0));
            wr(SCI_OFF_FCLR, rdat);
            wr(SCI_OFF_OLVL, 32'h0101);
        end
        // Parity field set: frame must not start
        wr(SCI_OFF_COMM, 32'h8110);
        wr(SCI_OFF_DATA, 32'h06a5);
        repeat (4) @(posedge pclk);
        chk(scl_oe, 1'b0);
        rd(SCI_OFF_STAT, 32'h40, 32'h0);
        test_done;
    end
endmodule : test_sci_channel
`default_nettype wire
